/* pcf_map.vh */
/*
 * Constants for the configuration transaction forwarder: bus commands,
 * address field positions, access type codes and forwarding kinds.
 * Assumes PCI command encodings on active-low C/BE# lines.
 */
`ifndef PCF_MAP_VH
`define PCF_MAP_VH

// Bus commands on C/BE#[3:0] during the address phase
`define PCF_CMD_CFG_RD   4'hA
`define PCF_CMD_CFG_WR   4'hB
`define PCF_CMD_SPECIAL  4'h1

// Access type in AD[1:0]
`define PCF_TYPE0        2'h0
`define PCF_TYPE1        2'h1

// Address field positions
`define PCF_BUS_MSB      23
`define PCF_BUS_LSB      16
`define PCF_DEV_MSB      15
`define PCF_DEV_LSB      11
`define PCF_FN_MSB       10
`define PCF_FN_LSB       8
`define PCF_REG_MSB      7
`define PCF_REG_LSB      2

// Device, function and register values for special cycle and upstream decoding
`define PCF_DEV_ALL      5'h1F
`define PCF_FN_ALL       3'h7
`define PCF_REG_ZERO     6'h00

// Secondary IDSEL lines on S_AD[31:16]
`define PCF_IDSEL_LINES  16

// Forwarding kinds held in the delayed entry
`define PCF_KIND_T0      2'h0
`define PCF_KIND_T1      2'h1
`define PCF_KIND_SPC     2'h2

// Target state machine
`define PCF_ST_IDLE      2'h0
`define PCF_ST_WAIT      2'h1
`define PCF_ST_TERM      2'h2

`endif

/* pcf_idsel.v */
/*
 * One-hot IDSEL pattern from a 5-bit device number.
 * Device numbers at or above LINES select nothing.
 */
`timescale 1ns/1ps
module pcf_idsel
#(
   parameter LINES = 16
)
(
   input  wire [4:0]       dev_num,
   output wire [LINES-1:0] idsel
);

   genvar g;
   generate
      for (g = 0; g < LINES; g = g + 1)
      begin : g_line
         localparam [4:0] DEV = g;
         assign idsel[g] = (dev_num == DEV);
      end
   endgenerate

endmodule // pcf_idsel

/* pcf_decode.v */
/*
 * Address phase classifier for one bus port: own Type 0, Type 1 to
 * Type 0 translation, Type 1 forwarding down and up, special cycle.
 * Assumes AD and C/BE# are sampled in the address phase.
 */
`timescale 1ns/1ps
`include "pcf_map.vh"
module pcf_decode
(
   input  wire [31:0] ad,
   input  wire [3:0]  cbe_n,
   input  wire        idsel,
   input  wire [7:0]  sec_bus,
   input  wire [7:0]  sub_bus,
   output wire        own_t0,
   output wire        t1_to_t0,
   output wire        t1_down,
   output wire        t1_up,
   output wire        special,
   output wire [31:0] xaddr,
   output wire [3:0]  xcmd
);

   wire        is_rd  = (cbe_n == `PCF_CMD_CFG_RD);
   wire        is_wr  = (cbe_n == `PCF_CMD_CFG_WR);
   wire        is_cfg = is_rd | is_wr;
   wire        type0  = (ad[1:0] == `PCF_TYPE0);
   wire        type1  = (ad[1:0] == `PCF_TYPE1);
   wire [7:0]  bus    = ad[`PCF_BUS_MSB:`PCF_BUS_LSB];
   wire [4:0]  dev    = ad[`PCF_DEV_MSB:`PCF_DEV_LSB];
   wire [2:0]  fn     = ad[`PCF_FN_MSB:`PCF_FN_LSB];
   wire [5:0]  regn   = ad[`PCF_REG_MSB:`PCF_REG_LSB];
   wire [`PCF_IDSEL_LINES-1:0] sel;

   pcf_idsel #(.LINES(`PCF_IDSEL_LINES)) u_idsel
   (
      .dev_num (dev),
      .idsel   (sel)
   );

   // Function number not looked at for own space
   assign own_t0   = is_cfg & type0 & idsel;
   assign t1_to_t0 = is_cfg & type1 & (bus == sec_bus);
   assign t1_down  = is_cfg & type1 & (bus > sec_bus)
                     & (bus <= sub_bus);
   assign t1_up    = is_wr & type1 & ((bus < sec_bus) | (bus > sub_bus))
                     & (dev == `PCF_DEV_ALL)
                     & (fn == `PCF_FN_ALL);
   assign special  = t1_to_t0 & is_wr & (dev == `PCF_DEV_ALL)
                     & (regn != `PCF_REG_ZERO);

   // Special cycle keeps the address; translation rebuilds it
   assign xaddr = special ? ad
                  : {sel, 5'h00, ad[`PCF_FN_MSB:`PCF_REG_LSB],
                     `PCF_TYPE0};
   assign xcmd  = special ? `PCF_CMD_SPECIAL : cbe_n;

endmodule // pcf_decode

/* pcf_forwarder.v */
/*
 * Configuration transaction target and forwarding front end of a
 * two-port PCI bridge. Port 0 is the primary bus, port 1 the secondary.
 * Assumes a separate forwarding engine runs the delayed cycle on the
 * far bus and reports done, master abort and read data; the bridge's
 * own configuration space answers reads combinationally.
 */
// How it works
// - Low bits 00 mean Type 0
// - Low bits 01 mean Type 1
// - Claim own Type 0 only with IDSEL
// - Never claim Type 0 on secondary bus
// - One DWORD, disconnect if more requested
// - Own reads return all four bytes
// - Own accesses complete at once, never retry
// - Type 1 to own secondary bus: translate
// - Type 0 generated only on secondary bus
// - Type 0 code, zero dev field, function and register kept
// - Devices 0-15 get one-hot IDSEL
// - Devices 16-30: no IDSEL, still forwarded
// - Device 31 writes: special cycle unless register zero
// - Translated cycles delayed, one 32-bit transfer
// - Subordinate range Type 1 passes down unchanged
// - Out-of-range all-ones writes pass upstream
// - Type 1 forwards delayed, one transfer
// - Function number ignored for own space
// - Latch request fields, then retry initiator
`timescale 1ns/1ps
`include "pcf_map.vh"
module pcf_forwarder
(
   input  wire        sys_clk,
   input  wire        srst,
   input  wire [7:0]  sec_bus_num,
   input  wire [7:0]  sub_bus_num,
   // Primary bus
   input  wire        p_frame_n,
   input  wire        p_irdy_n,
   input  wire [31:0] p_ad_in,
   input  wire [3:0]  primary_cmd_byte_enable_n,
   input  wire        primary_device_select_strobe,
   input  wire        p_par,
   output wire        primary_target_claim_n,
   output wire        primary_target_claim_oe,
   output wire        p_trdy_n,
   output wire        p_trdy_oe,
   output wire        p_stop_n,
   output wire        p_stop_oe,
   output wire [31:0] p_ad_out,
   output wire        p_ad_oe,
   // Secondary bus
   input  wire        s_frame_n,
   input  wire        s_irdy_n,
   input  wire [31:0] s_ad_in,
   input  wire [3:0]  s_cbe_n,
   input  wire        s_par,
   output wire        s_devsel_n,
   output wire        s_devsel_oe,
   output wire        s_trdy_n,
   output wire        s_trdy_oe,
   output wire        s_stop_n,
   output wire        s_stop_oe,
   output wire [31:0] s_ad_out,
   output wire        s_ad_oe,
   // Own configuration space
   output wire [5:0]  cfg_reg_num,
   input  wire [31:0] cfg_rd_data,
   output reg         cfg_wr_en_q,
   output reg  [31:0] cfg_wr_data_q,
   output reg  [3:0]  cfg_wr_be_n_q,
   // Forwarding engine
   output reg         fwd_req_q,
   output reg         fwd_upstream_q,
   output reg  [1:0]  fwd_kind_q,
   output reg  [31:0] fwd_addr_q,
   output reg  [3:0]  fwd_cmd_q,
   output reg  [3:0]  fwd_be_n_q,
   output reg         fwd_par_q,
   output reg  [31:0] fwd_wdata_q,
   input  wire        fwd_done,
   input  wire        fwd_master_abort,
   input  wire [31:0] fwd_rdata
);

   // Port views
   wire [1:0]  frame_n = {s_frame_n, p_frame_n};
   wire [1:0]  irdy_n  = {s_irdy_n, p_irdy_n};
   wire [63:0] ad_in   = {s_ad_in, p_ad_in};
   wire [7:0]  cbe_n   = {s_cbe_n, primary_cmd_byte_enable_n};
   wire [1:0]  par_in  = {s_par, p_par};
   wire [1:0]  idsel   = {1'b0, primary_device_select_strobe};

   wire [1:0]  devsel_w;
   wire [1:0]  trdy_w;
   wire [1:0]  stop_w;
   wire [1:0]  ctl_oe_w;
   wire [1:0]  ad_oe_w;
   wire [63:0] ad_out_w;
   wire [1:0]  set_w;
   wire [1:0]  clr_w;
   wire [1:0]  free_w;
   wire [1:0]  own_fire_w;
   wire [63:0] lat_ad_w;
   wire [63:0] lat_xaddr_w;
   wire [7:0]  lat_xcmd_w;
   wire [3:0]  lat_kind_w;
   wire [1:0]  lat_par_w;

   // Single delayed transaction entry
   reg         dq_valid_q;
   reg         dq_done_q;
   reg         dq_abort_q;
   reg         dq_port_q;
   reg  [31:0] dq_addr_q;
   reg  [3:0]  dq_cmd_q;
   reg  [1:0]  dq_kind_q;
   reg  [31:0] dq_rdata_q;

   assign free_w[0] = ~dq_valid_q;
   assign free_w[1] = ~dq_valid_q & ~set_w[0];

   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1)
      begin : g_port
         localparam       IS_PRI = (i == 0);
         localparam [0:0] PNUM   = i;
         wire [31:0] ad  = ad_in[32*i+31:32*i];
         wire [3:0]  cbe = cbe_n[4*i+3:4*i];
         wire        own_t0;
         wire        t1_to_t0;
         wire        t1_down;
         wire        t1_up;
         wire        special;
         wire [31:0] xaddr;
         wire [3:0]  xcmd;
         reg  [1:0]  st_q;
         reg         frame_prev_q;
         reg         addr_d1_q;
         reg         own_q;
         reg         hit_q;
         reg         rd_q;
         reg  [31:0] ad_q;
         reg  [31:0] xaddr_q;
         reg  [3:0]  xcmd_q;
         reg  [1:0]  kind_q;
         reg         par_q;
         reg         devsel_q;
         reg         trdy_q;
         reg         stop_q;
         reg         ctl_oe_q;
         reg         ad_oe_q;
         reg  [31:0] ad_out_q;

         pcf_decode u_dec
         (
            .ad       (ad),
            .cbe_n    (cbe),
            .idsel    (idsel[i]),
            .sec_bus  (sec_bus_num),
            .sub_bus  (sub_bus_num),
            .own_t0   (own_t0),
            .t1_to_t0 (t1_to_t0),
            .t1_down  (t1_down),
            .t1_up    (t1_up),
            .special  (special),
            .xaddr    (xaddr),
            .xcmd     (xcmd)
         );

         // Secondary side only forwards upward, never Type 0
         wire want_own = IS_PRI ? own_t0 : 1'b0;
         wire want_dly = IS_PRI ? (t1_to_t0 | t1_down)
                                : t1_up;
         wire match    = dq_valid_q & (dq_port_q == PNUM)
                         & (dq_addr_q == ad) & (dq_cmd_q == cbe);
         wire hit      = match & dq_done_q;
         // Expected abort of a special cycle still completes
         wire refl_ab  = hit & dq_abort_q & (dq_kind_q != `PCF_KIND_SPC);
         wire start    = ~frame_n[i] & frame_prev_q
                         & (st_q == `PCF_ST_IDLE);
         wire data_ph  = (st_q == `PCF_ST_WAIT) & ~irdy_n[i];

         assign set_w[i]      = data_ph & ~own_q & ~hit_q & free_w[i];
         assign clr_w[i]      = (data_ph & hit_q) | (start & refl_ab);
         assign own_fire_w[i] = data_ph & own_q;
         assign devsel_w[i]   = devsel_q;
         assign trdy_w[i]     = trdy_q;
         assign stop_w[i]     = stop_q;
         assign ctl_oe_w[i]   = ctl_oe_q;
         assign ad_oe_w[i]    = ad_oe_q;
         assign ad_out_w[32*i+31:32*i]     = ad_out_q;
         assign lat_ad_w[32*i+31:32*i]     = ad_q;
         assign lat_xaddr_w[32*i+31:32*i]  = xaddr_q;
         assign lat_xcmd_w[4*i+3:4*i]      = xcmd_q;
         assign lat_kind_w[2*i+1:2*i]      = kind_q;
         assign lat_par_w[i]               = par_q;

         always @(posedge sys_clk)
         begin
            if (srst)
            begin
               st_q         <= `PCF_ST_IDLE;
               frame_prev_q <= 1'b1;
               addr_d1_q    <= 1'b0;
               own_q        <= 1'b0;
               hit_q        <= 1'b0;
               rd_q         <= 1'b0;
               ad_q         <= 32'h0000_0000;
               xaddr_q      <= 32'h0000_0000;
               xcmd_q       <= 4'h0;
               kind_q       <= `PCF_KIND_T0;
               par_q        <= 1'b0;
               devsel_q     <= 1'b0;
               trdy_q       <= 1'b0;
               stop_q       <= 1'b0;
               ctl_oe_q     <= 1'b0;
               ad_oe_q      <= 1'b0;
               ad_out_q     <= 32'h0000_0000;
            end
            else
            begin
               frame_prev_q <= frame_n[i];
               addr_d1_q    <= start;
               if (addr_d1_q)
                  par_q <= par_in[i];
               case (st_q)
                  `PCF_ST_IDLE:
                  begin
                     ctl_oe_q <= 1'b0;
                     ad_oe_q  <= 1'b0;
                     // Unmatched cycles and aborted non-special cycles are left alone
                     if (start & (want_own | (want_dly & ~refl_ab)))
                     begin
                        st_q     <= `PCF_ST_WAIT;
                        devsel_q <= 1'b1;
                        ctl_oe_q <= 1'b1;
                        own_q    <= want_own;
                        hit_q    <= hit;
                        rd_q     <= (cbe == `PCF_CMD_CFG_RD);
                        ad_q     <= ad;
                        xaddr_q  <= (IS_PRI & t1_to_t0) ? xaddr : ad;
                        xcmd_q   <= (IS_PRI & t1_to_t0) ? xcmd : cbe;
                        kind_q   <= (IS_PRI & special) ? `PCF_KIND_SPC :
                                    (IS_PRI & t1_to_t0) ? `PCF_KIND_T0 :
                                    `PCF_KIND_T1;
                     end
                  end
                  `PCF_ST_WAIT:
                  begin
                     if (data_ph)
                     begin
                        st_q <= `PCF_ST_TERM;
                        if (own_q | hit_q)
                        begin
                           // Disconnect with data if more phases follow
                           trdy_q  <= 1'b1;
                           stop_q  <= ~frame_n[i];
                           ad_oe_q <= rd_q;
                           ad_out_q <= own_q ? cfg_rd_data
                                             : dq_rdata_q;
                        end
                        else
                           stop_q <= 1'b1;
                     end
                  end
                  `PCF_ST_TERM:
                  begin
                     st_q     <= `PCF_ST_IDLE;
                     devsel_q <= 1'b0;
                     trdy_q   <= 1'b0;
                     stop_q   <= 1'b0;
                     ad_oe_q  <= 1'b0;
                  end
                  default:
                     st_q <= `PCF_ST_IDLE;
               endcase
            end
         end
      end
   endgenerate

   assign primary_target_claim_n  = ~devsel_w[0];
   assign primary_target_claim_oe = ctl_oe_w[0];
   assign p_trdy_n   = ~trdy_w[0];
   assign p_trdy_oe  = ctl_oe_w[0];
   assign p_stop_n   = ~stop_w[0];
   assign p_stop_oe  = ctl_oe_w[0];
   assign p_ad_out   = ad_out_w[31:0];
   assign p_ad_oe    = ad_oe_w[0];
   assign s_devsel_n  = ~devsel_w[1];
   assign s_devsel_oe = ctl_oe_w[1];
   assign s_trdy_n   = ~trdy_w[1];
   assign s_trdy_oe  = ctl_oe_w[1];
   assign s_stop_n   = ~stop_w[1];
   assign s_stop_oe  = ctl_oe_w[1];
   assign s_ad_out   = ad_out_w[63:32];
   assign s_ad_oe    = ad_oe_w[1];

   // Register number for own reads; function bits ignored
   assign cfg_reg_num = lat_ad_w[`PCF_REG_MSB:`PCF_REG_LSB];

   // Own configuration writes, no buffering
   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         cfg_wr_en_q   <= 1'b0;
         cfg_wr_data_q <= 32'h0000_0000;
         cfg_wr_be_n_q <= 4'hF;
      end
      else
      begin
         cfg_wr_en_q <= own_fire_w[0] & ~g_port[0].rd_q;
         if (own_fire_w[0])
         begin
            cfg_wr_data_q <= p_ad_in;
            cfg_wr_be_n_q <= primary_cmd_byte_enable_n;
         end
      end
   end

   // Delayed entry: load on first attempt, free on completion
   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         dq_valid_q     <= 1'b0;
         dq_done_q      <= 1'b0;
         dq_abort_q     <= 1'b0;
         dq_port_q      <= 1'b0;
         dq_addr_q      <= 32'h0000_0000;
         dq_cmd_q       <= 4'h0;
         dq_kind_q      <= `PCF_KIND_T0;
         dq_rdata_q     <= 32'h0000_0000;
         fwd_req_q      <= 1'b0;
         fwd_upstream_q <= 1'b0;
         fwd_kind_q     <= `PCF_KIND_T0;
         fwd_addr_q     <= 32'h0000_0000;
         fwd_cmd_q      <= 4'h0;
         fwd_be_n_q     <= 4'hF;
         fwd_par_q      <= 1'b0;
         fwd_wdata_q    <= 32'h0000_0000;
      end
      else
      begin
         fwd_req_q <= 1'b0;
         if (fwd_done & dq_valid_q & ~dq_done_q)
         begin
            dq_done_q  <= 1'b1;
            dq_abort_q <= fwd_master_abort;
            dq_rdata_q <= fwd_rdata;
         end
         if (clr_w[0] | clr_w[1])
            dq_valid_q <= 1'b0;
         if (set_w[0] | set_w[1])
         begin
            dq_valid_q     <= 1'b1;
            dq_done_q      <= 1'b0;
            dq_abort_q     <= 1'b0;
            dq_port_q      <= ~set_w[0];
            fwd_req_q      <= 1'b1;
            fwd_upstream_q <= ~set_w[0];
            if (set_w[0])
            begin
               dq_addr_q   <= lat_ad_w[31:0];
               dq_cmd_q    <= g_port[0].rd_q ? `PCF_CMD_CFG_RD
                                             : `PCF_CMD_CFG_WR;
               dq_kind_q   <= lat_kind_w[1:0];
               fwd_kind_q  <= lat_kind_w[1:0];
               fwd_addr_q  <= lat_xaddr_w[31:0];
               fwd_cmd_q   <= lat_xcmd_w[3:0];
               fwd_par_q   <= lat_par_w[0];
               fwd_be_n_q  <= primary_cmd_byte_enable_n;
               fwd_wdata_q <= p_ad_in;
            end
            else
            begin
               dq_addr_q   <= lat_ad_w[63:32];
               dq_cmd_q    <= `PCF_CMD_CFG_WR;
               dq_kind_q   <= lat_kind_w[3:2];
               fwd_kind_q  <= lat_kind_w[3:2];
               fwd_addr_q  <= lat_xaddr_w[63:32];
               fwd_cmd_q   <= lat_xcmd_w[7:4];
               fwd_par_q   <= lat_par_w[1];
               fwd_be_n_q  <= s_cbe_n;
               fwd_wdata_q <= s_ad_in;
            end
         end
      end
   end

endmodule // pcf_forwarder

/* pcf_forwarder_sva.sv */
/* Port checks for the configuration forwarder.
   Assumes binding to pcf_forwarder, one clock, srst active high. */
`timescale 1ns/1ps
module pcf_fwd_chk
(
   input wire        sys_clk,
   input wire        srst,
   input wire [31:0] p_ad_in,
   input wire [3:0]  primary_cmd_byte_enable_n,
   input wire        primary_device_select_strobe,
   input wire        primary_target_claim_n,
   input wire        p_trdy_n,
   input wire        p_stop_n,
   input wire [31:0] s_ad_in,
   input wire        s_devsel_n,
   input wire        fwd_req_q,
   input wire        fwd_upstream_q,
   input wire [1:0]  fwd_kind_q,
   input wire [31:0] fwd_addr_q,
   input wire [3:0]  fwd_cmd_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   claim_cfg_only_a: assert property ($fell(primary_target_claim_n) |->
      $past(primary_cmd_byte_enable_n[3:1]) == 3'h5 && !$past(p_ad_in[1]))
      else $error("primary claim on a non-config cycle");
   own_needs_sel_a: assert property ($fell(primary_target_claim_n) &&
      $past(p_ad_in[1:0]) == 2'h0 |-> $past(primary_device_select_strobe))
      else $error("own access claimed without select");
   sec_type0_a: assert property ($fell(s_devsel_n) |->
      $past(s_ad_in[1:0]) == 2'h1)
      else $error("secondary claim of a non Type 1 cycle");
   one_dword_a: assert property (!p_trdy_n |=>
      p_trdy_n && primary_target_claim_n)
      else $error("more than one data transfer");
   own_no_retry_a: assert property ($fell(primary_target_claim_n) &&
      $past(p_ad_in[1:0]) == 2'h0 |-> (p_stop_n || !p_trdy_n)[*5])
      else $error("own access retried");
   xlate_addr_a: assert property (fwd_req_q && fwd_kind_q == 2'h0 |->
      !fwd_upstream_q && fwd_addr_q[1:0] == 2'h0 && fwd_addr_q[15:11] == 5'h00)
      else $error("bad translated address");
   idsel_onehot_a: assert property (fwd_req_q && fwd_kind_q == 2'h0 |->
      $onehot0(fwd_addr_q[31:16]))
      else $error("select lines not one-hot");
   retry_first_a: assert property (fwd_req_q && !fwd_upstream_q |->
      !p_stop_n && p_trdy_n)
      else $error("request without retry");
   up_fields_a: assert property (fwd_req_q && fwd_upstream_q |->
      fwd_cmd_q == 4'hB && fwd_addr_q[15:8] == 8'hFF)
      else $error("bad upstream request");
   t1_code_a: assert property (fwd_req_q && fwd_kind_q == 2'h1 |->
      fwd_addr_q[1:0] == 2'h1)
      else $error("Type 1 forward lost its code");
endmodule // pcf_fwd_chk

bind pcf_forwarder pcf_fwd_chk u_chk (.sys_clk(sys_clk), .srst(srst),
   .p_ad_in(p_ad_in), .primary_cmd_byte_enable_n(primary_cmd_byte_enable_n),
   .primary_device_select_strobe(primary_device_select_strobe),
   .primary_target_claim_n(primary_target_claim_n), .p_trdy_n(p_trdy_n),
   .p_stop_n(p_stop_n), .s_ad_in(s_ad_in), .s_devsel_n(s_devsel_n),
   .fwd_req_q(fwd_req_q), .fwd_upstream_q(fwd_upstream_q),
   .fwd_kind_q(fwd_kind_q), .fwd_addr_q(fwd_addr_q), .fwd_cmd_q(fwd_cmd_q));

/* pcf_engine_model.sv */
/* Far-bus engine model: runs each delayed entry and reports back.
   Assumes fwd_req_q pulses one cycle with fields stable. */
`timescale 1ns/1ps
module pcf_engine_model
(
   input  wire        sys_clk,
   input  wire        srst,
   input  wire        slow,
   input  wire        fwd_req_q,
   input  wire [1:0]  fwd_kind_q,
   input  wire [31:0] fwd_addr_q,
   output reg         fwd_done,
   output reg         fwd_master_abort,
   output reg  [31:0] fwd_rdata
);
   integer wait_q;
   always @(posedge sys_clk)
   begin
      fwd_done <= 1'b0;
      fwd_rdata <= ~fwd_rdata;
      if (srst)
      begin
         wait_q <= 0;
         fwd_master_abort <= 1'b0;
      end
      else if (fwd_req_q)
         wait_q <= slow ? 12 : 2;
      else if (wait_q > 0)
      begin
         wait_q <= wait_q - 1;
         if (wait_q == 1)
         begin
            fwd_done <= 1'b1;
            // Nobody answers a special cycle or an unselected device
            fwd_master_abort <= fwd_kind_q == 2'h2 ||
               (fwd_kind_q == 2'h0 && fwd_addr_q[31:16] == 16'h0000);
            fwd_rdata <= ~fwd_addr_q;
         end
      end
   end
endmodule // pcf_engine_model

/* pcf_forwarder_test.sv */
/* Self-checking bench: own space, translation, forwarding both ways.
   Assumes the engine model answers every delayed entry. */
`timescale 1ns/1ps
`include "pcf_map.vh"
module pcf_forwarder_test;
   localparam [7:0]  SEC = 8'h05;
   localparam [7:0]  SUB = 8'h07;
   localparam [31:0] WD = 32'hC0DEF00D;
   localparam [89:0] XT = {5'h00, 6'h05, 4'hA, 5'h09, 6'h05, 4'hB,
      5'h0F, 6'h05, 4'hA, 5'h10, 6'h05, 4'hA, 5'h1F, 6'h00, 4'hB,
      5'h1F, 6'h05, 4'hB};
   reg         sys_clk = 1'b0;
   reg         srst = 1'b1;
   reg         side = 1'b0;
   reg         frm_n = 1'b1;
   reg         irdy_n = 1'b1;
   reg  [31:0] ad = 32'h00000000;
   reg  [3:0]  cbe_n = 4'hF;
   reg         id = 1'b0;
   reg         slow = 1'b0;
   reg         dv, tr, st, dn, f_up;
   reg  [31:0] rd, f_addr, w_data;
   reg  [1:0]  f_kind;
   integer     f_cnt = 0, w_cnt = 0, fail_count = 0, comparisons = 0;
   wire        pc_n, p_trdy_n, p_stop_n, s_devsel_n, s_trdy_n, s_stop_n;
   wire [31:0] p_ad_out, s_ad_out, cfg_wr_data_q, fwd_addr_q, fwd_rdata;
   wire [5:0]  cfg_reg_num;
   wire [1:0]  fwd_kind_q;
   wire        cfg_wr_en_q, fwd_req_q, fwd_upstream_q, fwd_done;
   wire        fwd_master_abort;
   always #5 sys_clk = ~sys_clk;
   pcf_forwarder DUT (.sys_clk(sys_clk), .srst(srst), .sec_bus_num(SEC),
      .sub_bus_num(SUB), .p_frame_n(side | frm_n), .p_irdy_n(side | irdy_n),
      .p_ad_in(ad), .primary_cmd_byte_enable_n(cbe_n),
      .primary_device_select_strobe(id & !side), .p_par(1'b0),
      .primary_target_claim_n(pc_n), .primary_target_claim_oe(),
      .p_trdy_n(p_trdy_n), .p_trdy_oe(), .p_stop_n(p_stop_n), .p_stop_oe(),
      .p_ad_out(p_ad_out), .p_ad_oe(), .s_frame_n(!side | frm_n),
      .s_irdy_n(!side | irdy_n), .s_ad_in(ad), .s_cbe_n(cbe_n), .s_par(1'b0),
      .s_devsel_n(s_devsel_n), .s_devsel_oe(), .s_trdy_n(s_trdy_n),
      .s_trdy_oe(), .s_stop_n(s_stop_n), .s_stop_oe(), .s_ad_out(s_ad_out),
      .s_ad_oe(), .cfg_reg_num(cfg_reg_num),
      .cfg_rd_data({cfg_reg_num, 26'h2ABCDEF}), .cfg_wr_en_q(cfg_wr_en_q),
      .cfg_wr_data_q(cfg_wr_data_q), .cfg_wr_be_n_q(), .fwd_req_q(fwd_req_q),
      .fwd_upstream_q(fwd_upstream_q), .fwd_kind_q(fwd_kind_q),
      .fwd_addr_q(fwd_addr_q), .fwd_cmd_q(), .fwd_be_n_q(), .fwd_par_q(),
      .fwd_wdata_q(), .fwd_done(fwd_done),
      .fwd_master_abort(fwd_master_abort), .fwd_rdata(fwd_rdata));
   pcf_engine_model u_eng (.sys_clk(sys_clk), .srst(srst), .slow(slow),
      .fwd_req_q(fwd_req_q), .fwd_kind_q(fwd_kind_q),
      .fwd_addr_q(fwd_addr_q), .fwd_done(fwd_done),
      .fwd_master_abort(fwd_master_abort), .fwd_rdata(fwd_rdata));
   always @(posedge sys_clk)
   begin
      if (fwd_req_q === 1'b1)
         {f_cnt, f_addr, f_kind, f_up} <=
            {f_cnt + 1, fwd_addr_q, fwd_kind_q, fwd_upstream_q};
      if (cfg_wr_en_q === 1'b1)
         {w_cnt, w_data} <= {w_cnt + 1, cfg_wr_data_q};
      if (fwd_done === 1'b1)
         dn <= 1'b1;
   end
   task chk(input [31:0] exp, input [31:0] got, input [127:0] nm);
   begin
      comparisons = comparisons + 1;
      if (got !== exp)
      begin
         fail_count = fail_count + 1;
         $display("unexpected %0s: expected %h, seen %h", nm, exp, got);
      end
   end
   endtask
   // One configuration cycle; b keeps FRAME# low for a burst
   task bus_cyc(input s, input [31:0] a, input [3:0] c, input i, input b);
      integer n;
   begin
      @(negedge sys_clk);
      {side, ad, cbe_n, id, frm_n} = {s, a, c, i, 1'b0};
      @(negedge sys_clk);
      {ad, cbe_n, frm_n, irdy_n, dv, tr, st} = {WD, 4'h3, !b, 4'h0};
      for (n = 0; n < 8 && !tr && !st; n = n + 1)
      begin
         @(negedge sys_clk);
         dv = dv | ((side ? s_devsel_n : pc_n) === 1'b0);
         tr = (side ? s_trdy_n : p_trdy_n) === 1'b0;
         st = (side ? s_stop_n : p_stop_n) === 1'b0;
         rd = side ? s_ad_out : p_ad_out;
      end
      {ad, frm_n, irdy_n, cbe_n} = {~WD, 2'b11, 4'hF};
      repeat (3) @(negedge sys_clk);
   end
   endtask
   // First attempt of a delayed entry, then wait for the engine
   task first_try(input s, input [31:0] a, input [3:0] c, input [1:0] k,
      input [31:0] x);
      integer n;
   begin
      {n, dn} = {f_cnt, 1'b0};
      bus_cyc(s, a, c, 1'b0, 1'b0);
      chk({dv, tr, st}, 3'b101, "first attempt");
      chk(f_cnt - n, 1, "request count");
      chk({f_kind, f_up}, {k, s}, "kind");
      if (k != `PCF_KIND_SPC)
         chk(f_addr, x, "fwd address");
      for (n = 0; n < 40 && !dn; n = n + 1)
         @(negedge sys_clk);
   end
   endtask
   task t_own;
      integer w;
   begin
      w = w_cnt;
      bus_cyc(1'b0, 32'h00000710, `PCF_CMD_CFG_WR, 1'b1, 1'b0);
      chk({dv, tr, st}, 3'b110, "own write");
      chk({w_cnt - w, w_data}, {1, WD}, "write data");
      bus_cyc(1'b0, 32'h00000108, `PCF_CMD_CFG_RD, 1'b1, 1'b1);
      chk({dv, tr, st}, 3'b111, "own burst");
      chk(rd, {6'h02, 26'h2ABCDEF}, "own read");
      bus_cyc(1'b0, 32'h00000010, `PCF_CMD_CFG_RD, 1'b0, 1'b0);
      chk(dv, 1'b0, "no select");
      bus_cyc(1'b0, 32'h00000010, 4'h6, 1'b1, 1'b0);
      chk(dv, 1'b0, "memory read");
      bus_cyc(1'b1, 32'h00000010, `PCF_CMD_CFG_WR, 1'b1, 1'b0);
      chk(dv, 1'b0, "secondary type 0");
      $display("own space test done");
   end
   endtask
   task t_xlate;
      integer k;
      reg [14:0] e;
      reg [31:0] a, x;
      reg [1:0] kd;
   begin
      for (k = 0; k < 6; k = k + 1)
      begin
         e = XT[15*k +: 15];
         slow = k[0];
         a = {8'h00, SEC, e[14:10], 3'h2, e[9:4], 2'h1};
         x = {16'h0001 << e[14:10], 5'h00, 3'h2, e[9:4], 2'h0};
         kd = (e[14:10] == 5'h1F && e[9:4] != 6'h00) ? 2'h2 : 2'h0;
         first_try(1'b0, a, e[3:0], kd, x);
         bus_cyc(1'b0, a, e[3:0], 1'b0, 1'b1);
         if (kd == 2'h0 && x[31:16] == 16'h0000)
            chk(dv, 1'b0, "no device");
         else
            chk({dv, tr, st}, 3'b111, "repeat");
         if (kd == 2'h0 && e[3:0] == 4'hA && x[31:16] != 16'h0000)
            chk(rd, ~x, "read data");
      end
      $display("translation test done");
   end
   endtask
   task t_t1;
      reg [31:0] a;
   begin
      a = {8'h00, SUB, 16'h1805};
      first_try(1'b0, a, `PCF_CMD_CFG_RD, 2'h1, a);
      bus_cyc(1'b0, a, `PCF_CMD_CFG_RD, 1'b0, 1'b0);
      chk({dv, tr, st, rd}, {3'b110, ~a}, "down read");
      bus_cyc(1'b0, {8'h00, SUB + 8'h01, 16'h1805}, 4'hA, 1'b0, 1'b0);
      chk(dv, 1'b0, "beyond range");
      a = {8'h00, 8'h02, 16'hFF11};
      first_try(1'b1, a, `PCF_CMD_CFG_WR, 2'h1, a);
      bus_cyc(1'b1, a, `PCF_CMD_CFG_WR, 1'b0, 1'b0);
      chk({dv, tr, st}, 3'b110, "up repeat");
      bus_cyc(1'b1, {8'h00, SEC, 16'hFF11}, 4'hB, 1'b0, 1'b0);
      chk(dv, 1'b0, "up in range");
      bus_cyc(1'b1, {8'h00, 8'h02, 16'h1F11}, 4'hB, 1'b0, 1'b0);
      chk(dv, 1'b0, "up not all ones");
      $display("Type 1 forwarding test done");
   end
   endtask
   task wrap_up;
   begin
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   initial
   begin
      #100000;
      fail_count = fail_count + 1;
      wrap_up;
   end
   initial
   begin
      repeat (12) @(negedge sys_clk);
      srst = 1'b0;
      repeat (2) @(negedge sys_clk);
      t_own;
      t_xlate;
      t_t1;
      wrap_up;
   end
endmodule // pcf_forwarder_test
